// File: core/tfr_top.v
`timescale 1ns/1ps
`include "tfr_defines.vh"
`default_nettype none
module tfr_top #(
  parameter RESP_CYC = `TFR_RESP_CYC   // longest external response, cycles
) (
  // clock and reset
  input  wire        i_core_clk,
  input  wire        i_rst,
  // command port from the bus engine
  input  wire        i_cmd_wr,        // write strobe
  input  wire        i_cmd_rd,        // read strobe
  input  wire [7:0]  i_cmd_code,      // command code
  input  wire [7:0]  i_cmd_wdata,     // write data byte
  input  wire        i_clear_faults,  // clear-faults pulse
  input  wire        i_op_on,         // operation command on
  output reg  [7:0]  o_cmd_rdata,     // read data, next cycle
  // pins and sensors
  input  wire        i_run,           // run pin, asynchronous
  input  wire        i_die_hot,       // die overtemp comparator, asynchronous
  // external temperature conversions
  input  wire        i_adc_valid,     // conversion done pulse
  input  wire signed [15:0] i_adc_temp,  // conversion result
  input  wire signed [15:0] i_ot_limit,  // overtemp limit
  input  wire signed [15:0] i_ut_limit,  // undertemp limit
  input  wire        i_retry_tick,    // retry interval elapsed pulse
  // outputs
  output reg         o_output_en,     // power stage enable
  output reg  [7:0]  o_status_byte,   // status byte image
  output reg  [15:0] o_status_word,   // status word image
  output reg  [7:0]  o_status_mfr,    // manufacturer status image
  output reg  [7:0]  o_status_temp,   // temperature status image
  output reg         o_alert_out,     // alert pin level, always low
  output reg         o_alert_oe,      // alert pin pulled low
  output reg         o_adc_stale      // no conversion within response time
);
  //----------------------------------------------------------------
  // synchronisers
  //----------------------------------------------------------------
  reg  [1:0]  run_sync_ff;            // run pin stages
  reg  [1:0]  hot_sync_ff;            // die comparator stages
  reg         hot_prev_ff;            // previous synced die level
  wire        run_s = run_sync_ff[1];
  wire        hot_s = hot_sync_ff[1];
  // two stages for each asynchronous input
  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      run_sync_ff <= 2'b00;
      hot_sync_ff <= 2'b00;
      hot_prev_ff <= 1'b0;
    end
    else
    begin
      run_sync_ff <= {run_sync_ff[0], i_run};
      hot_sync_ff <= {hot_sync_ff[0], i_die_hot};
      hot_prev_ff <= hot_s;
    end
  end

  //----------------------------------------------------------------
  // action registers
  //----------------------------------------------------------------
  reg  [7:0]  ext_overtemp_action_ff;   // external overtemp action
  reg  [7:0]  ext_undertemp_action_ff;  // external undertemp action
  reg  [7:0]  die_overtemp_action_ff;   // die overtemp action
  wire [1:0]  wr_resp  = i_cmd_wdata[`TFR_RESP_HI:`TFR_RESP_LO];
  wire [2:0]  wr_retry = i_cmd_wdata[`TFR_RETRY_HI:`TFR_RETRY_LO];
  wire        wr_ext   = i_cmd_wr & ((i_cmd_code == `TFR_CMD_EXT_OT) | (i_cmd_code == `TFR_CMD_EXT_UT));
  wire        wr_die   = i_cmd_wr & (i_cmd_code == `TFR_CMD_DIE_OT);
  wire        die_bad_resp = (wr_resp == `TFR_RESP_CONT) | (wr_resp == `TFR_RESP_NS1);
  wire        die_bad_retry = (wr_retry != `TFR_RETRY_NONE);
  // external bytes reject the two unsupported responses
  wire        ext_bad = (wr_resp == `TFR_RESP_NS1) | (wr_resp == `TFR_RESP_HICCUP);
  wire        cml_evt = (wr_die & (die_bad_resp | die_bad_retry)) | (wr_ext & ext_bad);
  // register writes, rejected values leave the old contents
  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ext_overtemp_action_ff  <= `TFR_RST_EXT;
      ext_undertemp_action_ff <= `TFR_RST_EXT;
      die_overtemp_action_ff  <= `TFR_RST_DIE;
    end
    else
    begin
      if (i_cmd_wr & (i_cmd_code == `TFR_CMD_EXT_OT) & ~ext_bad)
        ext_overtemp_action_ff <= i_cmd_wdata;
      if (i_cmd_wr & (i_cmd_code == `TFR_CMD_EXT_UT) & ~ext_bad)
        ext_undertemp_action_ff <= i_cmd_wdata;
      if (wr_die & ~die_bad_resp & ~die_bad_retry)
        die_overtemp_action_ff <= i_cmd_wdata;
    end
  end
  // read mux, unmapped codes answer zero
  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
      o_cmd_rdata <= `TFR_RD_NONE;
    else if (i_cmd_rd)
      case (i_cmd_code)
        `TFR_CMD_EXT_OT: o_cmd_rdata <= ext_overtemp_action_ff;
        `TFR_CMD_EXT_UT: o_cmd_rdata <= ext_undertemp_action_ff;
        `TFR_CMD_DIE_OT: o_cmd_rdata <= die_overtemp_action_ff;
        default:         o_cmd_rdata <= `TFR_RD_NONE;
      endcase
  end

  //----------------------------------------------------------------
  // on/off command and fault clearing
  //----------------------------------------------------------------
  reg         cmd_on_ff;              // previous commanded-on state
  wire        cmd_on   = run_s & i_op_on;
  wire        turn_on  = cmd_on & ~cmd_on_ff;
  wire        turn_off = ~cmd_on & cmd_on_ff;
  wire        clr = i_clear_faults | turn_on;

  //----------------------------------------------------------------
  // fault detection
  //----------------------------------------------------------------
  reg         ot_prev_ff;             // last conversion over limit
  reg         ut_prev_ff;             // last conversion under limit
  wire        ot_now   = i_adc_temp > i_ot_limit;
  wire        ut_now   = i_adc_temp < i_ut_limit;
  wire        ot_evt   = i_adc_valid & ot_now & ~ot_prev_ff;
  wire        ut_evt   = i_adc_valid & ut_now & ~ut_prev_ff;
  // die fault on rising comparator
  wire        die_evt  = hot_s & ~hot_prev_ff;

  // conversion age watchdog
  reg  [23:0] age_ff;                 // cycles since last conversion
  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      age_ff      <= 24'h00_0000;
      o_adc_stale <= 1'b0;
    end
    else
    begin
      if (i_adc_valid)
        age_ff <= 24'h00_0000;
      else if (age_ff < RESP_CYC[23:0])
        age_ff <= age_ff + 24'h00_0001;
      o_adc_stale <= (age_ff >= RESP_CYC[23:0]);
    end
  end

  //----------------------------------------------------------------
  // sticky status, set wins over clear
  //----------------------------------------------------------------
  reg         die_sts_ff;             // die overtemp seen
  reg         ot_sts_ff;              // external overtemp seen
  reg         ut_sts_ff;              // external undertemp seen
  reg         cml_sts_ff;             // rejected write seen
  // sticky flags plus on/off and conversion history
  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      die_sts_ff <= 1'b0;
      ot_sts_ff  <= 1'b0;
      ut_sts_ff  <= 1'b0;
      cml_sts_ff <= 1'b0;
      cmd_on_ff  <= 1'b0;
      ot_prev_ff <= 1'b0;
      ut_prev_ff <= 1'b0;
    end
    else
    begin
      die_sts_ff <= die_evt | (die_sts_ff & ~clr);
      ot_sts_ff  <= ot_evt  | (ot_sts_ff & ~clr);
      ut_sts_ff  <= ut_evt  | (ut_sts_ff & ~clr);
      cml_sts_ff <= cml_evt | (cml_sts_ff & ~clr);
      cmd_on_ff  <= cmd_on;                              // on/off edge history
      ot_prev_ff <= i_adc_valid ? ot_now : ot_prev_ff;   // held between conversions
      ut_prev_ff <= i_adc_valid ? ut_now : ut_prev_ff;   // held between conversions
    end
  end

  //----------------------------------------------------------------
  // shutdown latches
  //----------------------------------------------------------------
  reg         die_sd_ff;              // die shutdown held
  reg         ot_sd_ff;               // external overtemp shutdown held
  reg         ut_sd_ff;               // external undertemp shutdown held
  wire [1:0]  die_resp = die_overtemp_action_ff[`TFR_RESP_HI:`TFR_RESP_LO];
  wire [1:0]  ot_resp  = ext_overtemp_action_ff[`TFR_RESP_HI:`TFR_RESP_LO];
  wire [1:0]  ut_resp  = ext_undertemp_action_ff[`TFR_RESP_HI:`TFR_RESP_LO];
  wire        ot_retry = ext_overtemp_action_ff[`TFR_RETRY_HI:`TFR_RETRY_LO] != `TFR_RETRY_NONE;
  wire        ut_retry = ext_undertemp_action_ff[`TFR_RETRY_HI:`TFR_RETRY_LO] != `TFR_RETRY_NONE;
  wire        sd_clr   = clr | turn_off;
  // shutdown latches, set wins over release
  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      die_sd_ff <= 1'b0;
      ot_sd_ff  <= 1'b0;
      ut_sd_ff  <= 1'b0;
    end
    else
    begin
      die_sd_ff <= (die_evt & (die_resp == `TFR_RESP_STOP)) | (die_sd_ff & ~sd_clr);
      ot_sd_ff  <= (ot_evt & (ot_resp == `TFR_RESP_STOP)) |
                   (ot_sd_ff & ~sd_clr & ~(i_retry_tick & ot_retry));
      ut_sd_ff  <= (ut_evt & (ut_resp == `TFR_RESP_STOP)) |
                   (ut_sd_ff & ~sd_clr & ~(i_retry_tick & ut_retry));
    end
  end

  //----------------------------------------------------------------
  // registered outputs
  //----------------------------------------------------------------
  // hiccup gate follows comparator
  wire        die_hold = hot_s & (die_resp == `TFR_RESP_HICCUP);
  wire        any_sts  = die_sts_ff | ot_sts_ff | ut_sts_ff | cml_sts_ff;
  // registered pin and status images
  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_output_en   <= 1'b0;
      o_status_byte <= 8'h00;
      o_status_word <= 16'h0000;
      o_status_mfr  <= 8'h00;
      o_status_temp <= 8'h00;
      o_alert_out   <= 1'b0;
      o_alert_oe    <= 1'b0;
    end
    else
    begin
      o_output_en <= cmd_on & ~die_sd_ff & ~ot_sd_ff & ~ut_sd_ff & ~die_hold;
      o_status_byte                 <= 8'h00;
      o_status_byte[`TFR_SB_NOTA]   <= die_sts_ff;
      o_status_byte[`TFR_SB_CML]    <= cml_sts_ff;
      o_status_byte[`TFR_SB_TEMP]   <= ot_sts_ff | ut_sts_ff;
      o_status_word                 <= 16'h0000;
      o_status_word[`TFR_SB_NOTA]   <= die_sts_ff;
      o_status_word[`TFR_SB_CML]    <= cml_sts_ff;
      o_status_word[`TFR_SB_TEMP]   <= ot_sts_ff | ut_sts_ff;
      o_status_word[`TFR_SW_MFR]    <= die_sts_ff;
      o_status_mfr                  <= 8'h00;
      o_status_mfr[`TFR_SM_OT]      <= die_sts_ff;
      o_status_temp                 <= 8'h00;
      o_status_temp[`TFR_ST_OT]     <= ot_sts_ff;
      o_status_temp[`TFR_ST_UT]     <= ut_sts_ff;
      // alert held until clear-faults pulse or turn-on edge clears the flags
      o_alert_oe  <= any_sts;
      o_alert_out <= 1'b0;
    end
  end

endmodule // tfr_top
`default_nettype wire

// File: core/tfr_defines.vh
`ifndef TFR_DEFINES_VH
`define TFR_DEFINES_VH
// command codes
`define TFR_CMD_EXT_OT        8'h50
`define TFR_CMD_EXT_UT        8'h54
`define TFR_CMD_DIE_OT        8'hD6
// power-up values
`define TFR_RST_EXT           8'hB8
`define TFR_RST_DIE           8'hC0
`define TFR_RD_NONE           8'h00
// action byte fields
`define TFR_RESP_HI           7
`define TFR_RESP_LO           6
`define TFR_RETRY_HI          5
`define TFR_RETRY_LO          3
// response codes
`define TFR_RESP_CONT         2'b00
`define TFR_RESP_NS1          2'b01
`define TFR_RESP_STOP         2'b10
`define TFR_RESP_HICCUP       2'b11
// retry codes
`define TFR_RETRY_NONE        3'b000
// status bit positions
`define TFR_SB_NOTA           0
`define TFR_SB_CML            1
`define TFR_SB_TEMP           2
`define TFR_SW_MFR            12
`define TFR_SM_OT             6
`define TFR_ST_OT             7
`define TFR_ST_UT             4
// timing
`define TFR_CLK_HZ            10000000
`define TFR_RESP_MS           80
`define TFR_RESP_CYC          ((`TFR_RESP_MS * `TFR_CLK_HZ) / 1000)
`endif

// File: verif/tfr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// host answering alert with a clear pulse
// ----------------------------------------
module tfr_host_model (
  input  wire logic i_core_clk,  // core clock
  input  wire logic i_en,        // host allowed to act
  input  wire logic i_alert_oe,  // alert pulled low
  output var  logic o_clear      // clear-faults pulse
);
  logic [1:0] wait_ff = 2'h0;    // cycles alert has been seen
  initial o_clear = 1'b0;
  always @(negedge i_core_clk)
  begin
    o_clear <= 1'b0;
    if (i_en && i_alert_oe && !o_clear)
      wait_ff <= wait_ff + 2'h1;
    else
      wait_ff <= 2'h0;
    if (wait_ff == 2'h3)
      o_clear <= 1'b1;
  end
endmodule // tfr_host_model
`default_nettype wire

// File: verif/tfr_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module tfr_asserts #(
  parameter RESP_CYC = 20  // stale span, cycles
) (
  input wire logic               i_core_clk,
  input wire logic               i_rst,
  input wire logic               i_cmd_wr,
  input wire logic [7:0]         i_cmd_code,
  input wire logic [7:0]         i_cmd_wdata,
  input wire logic               i_clear_faults,
  input wire logic               i_op_on,
  input wire logic               i_run,
  input wire logic               i_die_hot,
  input wire logic               i_adc_valid,
  input wire logic signed [15:0] i_adc_temp,
  input wire logic signed [15:0] i_ot_limit,
  input wire logic               o_output_en,
  input wire logic [7:0]         o_status_byte,
  input wire logic [15:0]        o_status_word,
  input wire logic [7:0]         o_status_mfr,
  input wire logic [7:0]         o_status_temp,
  input wire logic               o_alert_out,
  input wire logic               o_alert_oe
);
  logic prev_ot_ff;  // previous conversion was over the limit
  // remember the last conversion so only new faults count
  always_ff @(posedge i_core_clk or posedge i_rst)
    if (i_rst)
      prev_ot_ff <= 1'b0;
    else if (i_adc_valid)
      prev_ot_ff <= i_adc_temp > i_ot_limit;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  chk_word_mirror : assert property (o_status_word[7:0] == o_status_byte)
    else $error("status word low byte differs");
  chk_die_flags : assert property (o_status_mfr[6] |-> o_status_byte[0] && o_status_word[12])
    else $error("die flags inconsistent");
  chk_alert_any : assert property (o_alert_oe == (|{o_status_byte, o_status_mfr, o_status_temp}))
    else $error("alert not tied to status");
  chk_alert_low : assert property (o_alert_out == 1'b0)
    else $error("alert drive level high");
  chk_cml_die : assert property (i_cmd_wr && i_cmd_code == 8'hd6 &&
    (!i_cmd_wdata[7] || i_cmd_wdata[5:3] != 3'b000) |-> ##2 o_status_byte[1])
    else $error("bad die write gave no cml");
  chk_die_off : assert property (i_die_hot [*5] |=> !o_output_en)
    else $error("output on while die hot");
  chk_ext_over : assert property (i_adc_valid && i_adc_temp > i_ot_limit && !prev_ot_ff
    |-> ##2 (o_status_temp[7] && o_status_byte[2]))
    else $error("overtemp not flagged");
  chk_cml_sticky : assert property ((i_run && i_op_on && !i_clear_faults) [*6] ##0 o_status_byte[1]
    |=> o_status_byte[1])
    else $error("cml dropped without cause");
endmodule // tfr_asserts
bind tfr_top tfr_asserts #(.RESP_CYC(RESP_CYC)) i_tfr_asserts (.i_core_clk, .i_rst, .i_cmd_wr,
  .i_cmd_code, .i_cmd_wdata, .i_clear_faults, .i_op_on, .i_run, .i_die_hot, .i_adc_valid, .i_adc_temp,
  .i_ot_limit, .o_output_en, .o_status_byte, .o_status_word, .o_status_mfr, .o_status_temp,
  .o_alert_out, .o_alert_oe);
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic i_core_clk = 0, i_rst = 1, i_cmd_wr = 0, i_cmd_rd = 0, i_op_on = 1, i_run = 1;
  logic i_die_hot = 0, i_adc_valid = 0, i_retry_tick = 0, host_en = 0, i_clear_faults;
  logic [7:0] i_cmd_code = 0, i_cmd_wdata = 0, o_cmd_rdata, o_status_byte, o_status_mfr, o_status_temp;
  logic signed [15:0] i_adc_temp = 0, i_ot_limit = 16'h0064, i_ut_limit = 16'hffec;
  logic [15:0] o_status_word;
  logic o_output_en, o_alert_out, o_alert_oe, o_adc_stale;
  logic [7:0] shadow [0:255];  // expected register contents
  logic [7:0] codes [3] = '{8'h50, 8'h54, 8'hd6};
  int err_total = 0, comparisons = 0;
  always #50 i_core_clk = ~i_core_clk;
  tfr_top #(.RESP_CYC(20)) i_tfr_top (.i_core_clk, .i_rst, .i_cmd_wr, .i_cmd_rd, .i_cmd_code, .i_cmd_wdata,
    .i_clear_faults, .i_op_on, .o_cmd_rdata, .i_run, .i_die_hot, .i_adc_valid, .i_adc_temp, .i_ot_limit,
    .i_ut_limit, .i_retry_tick, .o_output_en, .o_status_byte, .o_status_word, .o_status_mfr,
    .o_status_temp, .o_alert_out, .o_alert_oe, .o_adc_stale);
  tfr_host_model i_tfr_host_model (.i_core_clk, .i_en(host_en), .i_alert_oe(o_alert_oe), .o_clear(i_clear_faults));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  // accepted writes: die needs stop/hiccup and no retry
  function automatic logic ok_wr(input logic [7:0] c, input logic [7:0] d);
    if (c == 8'hd6)
      return d[7] && d[5:3] == 3'b000;
    return d[7:6] == 2'b00 || d[7:6] == 2'b10;
  endfunction
  task automatic rd(input logic [7:0] c, input logic [7:0] exp);
    i_cmd_rd = 1;
    i_cmd_code = c;
    cyc(1);
    i_cmd_rd = 0;
    chk(o_cmd_rdata, exp, "read data");
    cyc(1);
  endtask
  task automatic clr;
    host_en = 1;
    for (int k = 0; k < 30 && o_alert_oe !== 1'b0; k++) cyc(1);
    host_en = 0;
    chk(o_alert_oe, 0, "alert after clear");
  endtask
  // clear, write, check cml and read back
  task automatic wrchk(input logic [7:0] c, input logic [7:0] d);
    clr;
    i_cmd_wr = 1;
    i_cmd_code = c;
    i_cmd_wdata = d;
    cyc(1);
    i_cmd_wr = 0;
    cyc(2);
    chk(o_status_byte[1], !ok_wr(c, d), "cml flag");
    if (ok_wr(c, d))
      shadow[c] = d;
    rd(c, shadow[c]);
  endtask
  task automatic adc(input logic [15:0] t);
    i_adc_valid = 1;
    i_adc_temp = t;
    cyc(1);
    i_adc_valid = 0;
    cyc(3);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial
  begin
    cyc(5000);
    err_total++;
    print_verdict;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(30436));
    shadow[8'h50] = 8'hb8;
    shadow[8'h54] = 8'hb8;
    shadow[8'hd6] = 8'hc0;
    cyc(4);
    i_rst = 0;
    cyc(4);
    chk(o_output_en, 1, "enabled after reset");
    rd(8'h50, 8'hb8);
    rd(8'h54, 8'hb8);
    rd(8'hd6, 8'hc0);
    rd(8'h33, 8'h00);
    wrchk(8'hd6, 8'hc7);
    i_die_hot = 1;
    cyc(6);
    chk(o_output_en, 0, "hiccup off");
    chk({o_status_byte[0], o_status_word[12], o_status_mfr[6], o_alert_oe}, 4'hf, "die flags");
    i_die_hot = 0;
    cyc(6);
    chk(o_output_en, 1, "hiccup back on");
    chk(o_status_mfr[6], 1, "die flag held");
    wrchk(8'hd6, 8'h80);
    i_die_hot = 1;
    cyc(6);
    chk(o_output_en, 0, "stop off");
    i_die_hot = 0;
    cyc(6);
    chk(o_output_en, 0, "stays off");
    clr;
    cyc(3);
    chk(o_output_en, 1, "on after clear");
    for (int v = 0; v < 10; v++) wrchk(8'hd6, v < 8 ? {2'b10, 3'(v), 3'b101} : {2'(v - 8), 6'h00});
    for (int i = 0; i < 8; i++) wrchk(codes[$urandom_range(2)], 8'($urandom));
    wrchk(8'h50, 8'h00);
    wrchk(8'h54, 8'hb8);
    adc(16'h0096);
    chk({o_status_temp[7], o_status_byte[2], o_output_en}, 3'b111, "ext over");
    i_op_on = 0;
    cyc(3);
    i_op_on = 1;
    cyc(6);
    chk(o_status_temp, 0, "op cycle clears");
    adc(16'h0096);
    chk(o_status_temp[7], 0, "no repeat overtemp");
    adc(16'hffce);
    chk({o_status_temp[4], o_status_byte[2], o_output_en}, 3'b110, "ext under");
    i_retry_tick = 1;
    cyc(1);
    i_retry_tick = 0;
    cyc(3);
    chk(o_output_en, 1, "retry restart");
    adc(16'h0000);
    chk(o_adc_stale, 0, "fresh conversion");
    cyc(25);
    chk(o_adc_stale, 1, "stale conversion");
    print_verdict;
  end
endmodule // tb
`default_nettype wire
